// ### dv/tcpri_partner.sv
// port partner model on the configuration channel
`timescale 1ns/10ps
module tcpri_partner (
  // bench control
  input  wire logic plug_src,
  input  wire logic plug_snk,
  input  wire logic flip,
  // device side
  input  wire logic acting_source,
  output logic      cc_sink_seen,
  output logic      cc_orient_cc1,
  output logic      cc_detach,
  output logic      bus_power_sense
);
  // a source partner offers vbus only while it sees our pulldowns
  assign bus_power_sense = plug_src & ~acting_source;
  assign cc_sink_seen    = plug_snk & acting_source;
  assign cc_detach       = acting_source & ~plug_snk;
  // unplugged lines float, so the orientation shows the inverse of flip
  assign cc_orient_cc1   = (plug_src | plug_snk) ? flip : ~flip;
endmodule : tcpri_partner

// ### dv/testbench.sv
// self-checking bench for the port role and power-up block
`timescale 1ns/10ps
module testbench;
  logic       clock = 0, reset_n = 0, chip_en_n = 0;
  logic       strap_level = 0, strap_float = 0;
  logic       role_wr = 0, soft_reset = 0, alert_clear = 0;
  logic [1:0] role_wdata = 0;
  logic       plug_src = 0, plug_snk = 0, flip = 0;
  logic       sink_seen, orient_cc1, detach, vbus;
  logic [1:0] role_sel;
  logic [6:0] target_addr;
  logic       i2c_mode, acting_source, pulldown_en, pullup_en, attached;
  logic       orient_flag, orient_pin, role_exit, alert_out, alert_oe_n;
  int         errors = 0, tests_run = 0, cycles = 0;

  always #4 clock = ~clock;

  tcpri_core #(.DRP_HALF(4)) tcpri_core_i (
    .clock(clock), .reset_n(reset_n), .chip_en_n(chip_en_n),
    .strap_level(strap_level), .strap_float(strap_float),
    .role_wr(role_wr), .role_wdata(role_wdata), .soft_reset(soft_reset),
    .alert_clear(alert_clear), .cc_sink_seen(sink_seen),
    .cc_orient_cc1(orient_cc1), .cc_detach(detach),
    .bus_power_sense(vbus), .role_sel(role_sel), .i2c_mode(i2c_mode),
    .target_addr(target_addr), .acting_source(acting_source),
    .pulldown_en(pulldown_en), .pullup_en(pullup_en),
    .attached(attached), .orient_flag(orient_flag),
    .orient_pin(orient_pin), .role_exit(role_exit),
    .change_alert_out(alert_out), .change_alert_oe_n(alert_oe_n));

  tcpri_partner tcpri_partner_i (
    .plug_src(plug_src), .plug_snk(plug_snk), .flip(flip),
    .acting_source(acting_source), .cc_sink_seen(sink_seen),
    .cc_orient_cc1(orient_cc1), .cc_detach(detach),
    .bus_power_sense(vbus));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // hang guard, far above the length of the sequence
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  // straps move only under reset, as a board strap would
  task automatic rst(input logic lvl, input logic flt);
    @(negedge clock);
    reset_n = 0;
    strap_level = lvl;
    strap_float = flt;
    repeat (6) @(negedge clock);
    chk(pulldown_en, 1);
    chk(pullup_en, 0);
    reset_n = 1;
    repeat (2) @(negedge clock);
  endtask : rst

  task automatic wr_role(input logic [1:0] v);
    @(negedge clock);
    role_wr = 1;
    role_wdata = v;
    #1 chk(role_exit, 1);
    @(negedge clock);
    role_wr = 0;
    chk(role_sel, v);
    chk(alert_oe_n, 0);
  endtask : wr_role

  task automatic wait_att(input logic exp);
    int n;
    n = 0;
    while (attached !== exp && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk(attached, exp);
  endtask : wait_att

  initial begin
    rst(1, 0);
    chk(target_addr, tcpri_pkg::ADDR_STRAP_HIGH);
    rst(0, 1);
    chk(i2c_mode, 0);
    rst(0, 0);
    chk(i2c_mode, 1);
    chk(target_addr, tcpri_pkg::ADDR_STRAP_LOW);
    chk(role_sel, tcpri_pkg::ROLE_DRP);
    chk(acting_source, 0);
    wr_role(tcpri_pkg::ROLE_UFP);
    repeat (10) @(negedge clock);
    chk(acting_source, 0);
    chk(attached, 0);
    plug_src = 1;
    flip = 1;
    wait_att(1);
    chk(orient_flag, tcpri_pkg::ORIENT_CC1);
    chk(orient_pin, tcpri_pkg::ORIENT_CC1);
    @(negedge clock);
    alert_clear = 1;
    @(negedge clock);
    alert_clear = 0;
    chk(alert_oe_n, 1);
    chk(alert_out, 0);
    // rewrite while attached must drop the link at once
    wr_role(tcpri_pkg::ROLE_DFP);
    plug_src = 0;
    plug_snk = 1;
    flip = 0;
    chk(attached, 0);
    // the exit lands in unattached sink; the new role shows a cycle later
    @(negedge clock);
    chk(acting_source, 1);
    chk(pullup_en, 1);
    wait_att(1);
    chk(orient_flag, tcpri_pkg::ORIENT_CC2);
    chk(orient_pin, tcpri_pkg::ORIENT_CC2);
    @(negedge clock);
    soft_reset = 1;
    #1 chk(role_exit, 1);
    @(negedge clock);
    soft_reset = 0;
    chk(role_sel, tcpri_pkg::ROLE_DRP);
    chk(attached, 0);
    wait_att(1);
    @(negedge clock);
    chip_en_n = 1;
    @(negedge clock);
    chip_en_n = 0;
    #1 chk(role_exit, 1);
    @(negedge clock);
    chk(attached, 0);
    stop_test();
  end
endmodule : testbench

// ### hdl/tcpri_core.sv
// port role selection, strap, alert, orientation and power-up sequencing
//
// Contract
// - role field 01 selects sink operation
// - role rewrite, soft reset, enable fall exit
// - strapped address pin enables control mode
// - strap low answers at address 0x47
// - register change pulls alert output low
// - orientation flag 0 is cc2, 1 cc1
// - orientation pin follows detected orientation
// - unpowered default is sink with pulldowns
// - power-on reset enters unattached sink, drp
// - unattached watches cc as source, vbus sink
// - active only after detected attach
// - role field 00 selects dual role
// - role field 10 selects source operation
`timescale 1ns/10ps
module tcpri_core #(
  parameter int DRP_HALF = tcpri_pkg::DRP_HALF_CYCLES
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // chip enable, active low
  input  wire logic       chip_en_n,
  // address strap: driven level and floating indication
  input  wire logic       strap_level,
  input  wire logic       strap_float,
  // register side
  input  wire logic       role_wr,
  input  wire logic [1:0] role_wdata,
  input  wire logic       soft_reset,
  input  wire logic       alert_clear,
  // link side
  input  wire logic       cc_sink_seen,
  input  wire logic       cc_orient_cc1,
  input  wire logic       cc_detach,
  input  wire logic       bus_power_sense,
  // status
  output logic [1:0]      role_sel,
  output logic            i2c_mode,
  output logic [6:0]      target_addr,
  output logic            acting_source,
  output logic            pulldown_en,
  output logic            pullup_en,
  output logic            attached,
  output logic            orient_flag,
  output logic            orient_pin,
  output logic            role_exit,
  // open-drain alert, oe low while pulling low
  output logic            change_alert_out,
  output logic            change_alert_oe_n
);

  tcpri_pkg::tcpri_state_e state;
  tcpri_pkg::tcpri_state_e next_state;
  logic        en_prev;
  logic        en_fall;
  logic        exit_req;
  logic        alert_pend;
  logic        reg_change;
  logic        drp_src;
  logic [31:0] drp_cnt;
  logic        attach_ok;

  // the enable pin going from high to low leaves the role
  assign en_fall  = en_prev & ~chip_en_n;
  assign exit_req = role_wr | soft_reset | en_fall;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // low, so a pin held low through reset shows no false fall
      en_prev <= 1'b0;
    end else begin
      en_prev <= chip_en_n;
    end
  end

  // role field; soft reset returns it to dual role
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      role_sel <= tcpri_pkg::ROLE_RST;
    end else if (soft_reset) begin
      role_sel <= tcpri_pkg::ROLE_RST;
    end else if (role_wr) begin
      role_sel <= role_wdata;
    end
  end

  // strap registered every cycle after reset release, not under reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      i2c_mode    <= 1'b0;
      target_addr <= tcpri_pkg::ADDR_STRAP_LOW;
    end else begin
      i2c_mode    <= ~strap_float;
      target_addr <= strap_level ? tcpri_pkg::ADDR_STRAP_HIGH
                                 : tcpri_pkg::ADDR_STRAP_LOW;
    end
  end

  // drp toggles between sink and source while unattached
  always_ff @(posedge clock) begin
    if (!reset_n || exit_req || state != tcpri_pkg::ST_UNATT_SK &&
        state != tcpri_pkg::ST_UNATT_SR) begin
      drp_cnt <= '0;
      drp_src <= 1'b0;
    end else if (role_sel == tcpri_pkg::ROLE_DRP) begin
      if (drp_cnt >= 32'(DRP_HALF - 1)) begin
        drp_cnt <= '0;
        drp_src <= ~drp_src;
      end else begin
        drp_cnt <= drp_cnt + 32'h1;
      end
    end
  end

  // attach: cc sees sink pulldown as source, vbus as sink
  assign attach_ok = acting_source ? cc_sink_seen : bus_power_sense;

  always_comb begin
    next_state = state;
    case (state)
      tcpri_pkg::ST_DEAD: begin
        next_state = tcpri_pkg::ST_UNATT_SK;
      end
      tcpri_pkg::ST_UNATT_SK, tcpri_pkg::ST_UNATT_SR: begin
        if (attach_ok) begin
          next_state = tcpri_pkg::ST_ACTIVE;
        end else if (acting_source) begin
          next_state = tcpri_pkg::ST_UNATT_SR;
        end else begin
          next_state = tcpri_pkg::ST_UNATT_SK;
        end
      end
      tcpri_pkg::ST_ACTIVE: begin
        if (acting_source ? cc_detach : ~bus_power_sense) begin
          next_state = tcpri_pkg::ST_UNATT_SK;
        end
      end
      default: next_state = tcpri_pkg::ST_UNATT_SK;
    endcase
    if (exit_req && state != tcpri_pkg::ST_DEAD) begin
      next_state = tcpri_pkg::ST_UNATT_SK;
    end
  end

  // reset leaves the port in the dead-battery sink default
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= tcpri_pkg::ST_DEAD;
    end else begin
      state <= next_state;
    end
  end

  // sink role holds while attached so a source drop cannot flip it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      acting_source <= 1'b0;
    end else if (exit_req) begin
      acting_source <= 1'b0;
    end else if (state != tcpri_pkg::ST_ACTIVE) begin
      case (role_sel)
        tcpri_pkg::ROLE_UFP: acting_source <= 1'b0;
        tcpri_pkg::ROLE_DFP: acting_source <= 1'b1;
        default:             acting_source <= drp_src;
      endcase
    end
  end

  assign pulldown_en = ~acting_source;
  assign pullup_en   = acting_source;
  assign role_exit   = exit_req;

  // orientation latched on attach
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      attached    <= 1'b0;
      orient_flag <= tcpri_pkg::ORIENT_RST;
      orient_pin  <= tcpri_pkg::ORIENT_RST;
    end else begin
      attached <= (next_state == tcpri_pkg::ST_ACTIVE);
      if (state != tcpri_pkg::ST_ACTIVE &&
          next_state == tcpri_pkg::ST_ACTIVE) begin
        orient_flag <= cc_orient_cc1 ? tcpri_pkg::ORIENT_CC1
                                     : tcpri_pkg::ORIENT_CC2;
        orient_pin  <= cc_orient_cc1;
      end
    end
  end

  // a role write, soft reset or attach change raises the alert; set beats clear
  assign reg_change = role_wr | soft_reset |
                      ((state == tcpri_pkg::ST_ACTIVE) !=
                       (next_state == tcpri_pkg::ST_ACTIVE));

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alert_pend <= 1'b0;
    end else if (reg_change) begin
      alert_pend <= 1'b1;
    end else if (alert_clear) begin
      alert_pend <= 1'b0;
    end
  end

  assign change_alert_out  = 1'b0;
  assign change_alert_oe_n = ~alert_pend;

  // assertions
  a_sink_role_fixed: assert property (
    @(posedge clock) disable iff (!reset_n)
    role_sel == tcpri_pkg::ROLE_UFP && !role_wr && !soft_reset &&
    state != tcpri_pkg::ST_ACTIVE |=> !acting_source)
    else $error("sink role not held");

  a_src_role_fixed: assert property (
    @(posedge clock) disable iff (!reset_n)
    role_sel == tcpri_pkg::ROLE_DFP && !exit_req &&
    state != tcpri_pkg::ST_ACTIVE |=> acting_source)
    else $error("source role not held");

  a_exit_restart: assert property (
    @(posedge clock) disable iff (!reset_n)
    exit_req && state != tcpri_pkg::ST_DEAD |=>
    state == tcpri_pkg::ST_UNATT_SK && !attached)
    else $error("role not left on exit");

  a_enable_fall: assert property (
    @(posedge clock) disable iff (!reset_n)
    $past(reset_n) && $past(chip_en_n) && !chip_en_n |-> role_exit)
    else $error("enable fall not an exit");

  a_exit_sink: assert property (
    @(posedge clock) disable iff (!reset_n)
    soft_reset |=> role_sel == tcpri_pkg::ROLE_DRP && !acting_source)
    else $error("soft reset did not restart");

  a_float_strap: assert property (
    @(posedge clock) disable iff (!reset_n)
    strap_float |=> !i2c_mode)
    else $error("floating strap gave control mode");

  a_addr_strap: assert property (
    @(posedge clock) disable iff (!reset_n)
    !strap_level && !strap_float |=>
    target_addr == tcpri_pkg::ADDR_STRAP_LOW && i2c_mode)
    else $error("wrong strapped address");

  a_alert_set: assert property (
    @(posedge clock) disable iff (!reset_n)
    role_wr |=> !change_alert_oe_n)
    else $error("alert not raised");

  // a clear in the same cycle as a change must lose
  a_alert_change: assert property (
    @(posedge clock) disable iff (!reset_n)
    reg_change |=> !change_alert_oe_n)
    else $error("alert lost to clear");

  a_alert_clear: assert property (
    @(posedge clock) disable iff (!reset_n)
    alert_clear && !reg_change |=> change_alert_oe_n)
    else $error("alert not released");

  a_orient_flag: assert property (
    @(posedge clock) disable iff (!reset_n)
    state != tcpri_pkg::ST_ACTIVE && next_state == tcpri_pkg::ST_ACTIVE
    |=> orient_flag == ($past(cc_orient_cc1) ? tcpri_pkg::ORIENT_CC1
                                             : tcpri_pkg::ORIENT_CC2))
    else $error("orientation flag coded wrong");

  a_orient_pin: assert property (
    @(posedge clock) disable iff (!reset_n)
    state != tcpri_pkg::ST_ACTIVE && next_state == tcpri_pkg::ST_ACTIVE
    |=> orient_pin == $past(cc_orient_cc1) && orient_flag == orient_pin)
    else $error("orientation not latched");

  a_dead_pulldown: assert property (
    @(posedge clock) disable iff (!reset_n)
    state == tcpri_pkg::ST_DEAD |-> pulldown_en && !pullup_en)
    else $error("dead state without pulldowns");

  a_active_cause: assert property (
    @(posedge clock) disable iff (!reset_n)
    state != tcpri_pkg::ST_ACTIVE ##1 state == tcpri_pkg::ST_ACTIVE |->
    $past(attach_ok))
    else $error("active without attach");

  a_unatt_watch: assert property (
    @(posedge clock) disable iff (!reset_n)
    state == tcpri_pkg::ST_UNATT_SK && !acting_source && bus_power_sense &&
    !exit_req |=> state == tcpri_pkg::ST_ACTIVE)
    else $error("vbus attach missed");

  a_drp_follow: assert property (
    @(posedge clock) disable iff (!reset_n)
    role_sel == tcpri_pkg::ROLE_DRP && !exit_req &&
    state != tcpri_pkg::ST_ACTIVE |=> acting_source == $past(drp_src))
    else $error("dual role not toggling");

  // runs through reset on purpose, so it carries no disable
  a_powerup_sink: assert property (
    @(posedge clock)
    $rose(reset_n) |-> state == tcpri_pkg::ST_DEAD && pulldown_en
    ##1 (state == tcpri_pkg::ST_UNATT_SK || state == tcpri_pkg::ST_ACTIVE))
    else $error("power-up path wrong");

endmodule : tcpri_core

// ### shared/tcpri_pkg.sv
// constants and types for the type-c port role and power-up block
package tcpri_pkg;

  // role select field encodings
  localparam logic [1:0] ROLE_DRP = 2'h0;
  localparam logic [1:0] ROLE_UFP = 2'h1;
  localparam logic [1:0] ROLE_DFP = 2'h2;
  localparam logic [1:0] ROLE_RST = 2'h0;

  // target address chosen by the strap
  localparam logic [6:0] ADDR_STRAP_LOW  = 7'h47;
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h67;

  // orientation flag encoding with swapped channel wiring
  localparam logic ORIENT_CC2 = 1'h0;
  localparam logic ORIENT_CC1 = 1'h1;
  localparam logic ORIENT_RST = 1'h0;

  // drp toggle half period
  localparam int DRP_HALF_NS     = 40000;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int DRP_HALF_CYCLES = DRP_HALF_NS / CLK_PERIOD_NS;

  // port states, one-hot
  typedef enum logic [3:0] {
    ST_DEAD     = 4'h1,
    ST_UNATT_SK = 4'h2,
    ST_UNATT_SR = 4'h4,
    ST_ACTIVE   = 4'h8
  } tcpri_state_e;

endpackage : tcpri_pkg
